// ---- quad_dac_pkg.sv ----
/*
 * Shared constants and types of the quad converter serial command control.
 * Assumes a single system clock domain; all pins are sampled into it.
 */
package quad_dac_pkg;

    // Frame layout
    localparam int FRAME_BITS   = 16;
    localparam int DATA_BITS    = 12;
    localparam int CHANNELS     = 4;
    localparam int SEL_HI_POS   = 15;
    localparam int SEL_LO_POS   = 14;
    localparam int CTL_HI_POS   = 13;
    localparam int CTL_LO_POS   = 12;
    localparam int DATA_MSB_POS = 11;

    // Control codes
    localparam logic [1:0] CTL_SPECIAL     = 2'h0;
    localparam logic [1:0] CTL_LOAD_INPUT  = 2'h1;
    localparam logic [1:0] CTL_MISC        = 2'h2;
    localparam logic [1:0] CTL_LOAD_UPDATE = 2'h3;

    // Select codes under the special control code
    localparam logic [1:0] SEL_NOP         = 2'h0;
    localparam logic [1:0] SEL_UPDATE_ALL  = 2'h1;
    localparam logic [1:0] SEL_LOAD_ALL    = 2'h2;
    localparam logic [1:0] SEL_SHUTDOWN    = 2'h3;

    // Select codes under the misc control code
    localparam logic [1:0] SEL_USER_LOW    = 2'h0;
    localparam logic [1:0] SEL_USER_HIGH   = 2'h1;
    localparam logic [1:0] SEL_ECHO_FALL   = 2'h2;
    localparam logic [1:0] SEL_ECHO_RISE   = 2'h3;

    // Reset values
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [15:0] FRAME_RESET    = 16'h0000;
    localparam logic        USER_OUT_RESET = 1'b0;
    localparam logic        ECHO_BIT_RESET = 1'b0;
    localparam logic        SHUTDOWN_RESET = 1'b0;

    // Timing: pins cross through this many flops
    localparam int SYNC_STAGES  = 2;
    localparam int CLOCK_HZ     = 10_000_000;
    localparam int SCLK_MAX_HZ  = 10_000_000;

    typedef enum logic {ECHO_FALLING, ECHO_RISING} echo_mode_t;
    typedef logic [DATA_BITS-1:0]  dac_word_t;
    typedef logic [FRAME_BITS-1:0] frame_t;

endpackage

// ---- serial_frame_if.sv ----
/*
 * Carrier between the serial shifter and the command core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface serial_frame_if
    import quad_dac_pkg::*;
();
    logic       sclkRise;
    logic       sclkFall;
    logic       selected;
    logic       dinBit;
    logic       clearAll;
    echo_mode_t echoMode;
    frame_t     frame;
    logic       echoBit;

    modport shifter
    (
        input  sclkRise,
        input  sclkFall,
        input  selected,
        input  dinBit,
        input  clearAll,
        input  echoMode,
        output frame,
        output echoBit
    );

    modport core
    (
        output sclkRise,
        output sclkFall,
        output selected,
        output dinBit,
        output clearAll,
        output echoMode,
        input  frame,
        input  echoBit
    );
endinterface

// ---- pin_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the pins are asynchronous to clock; reset is synchronous.
 */
`timescale 1ns/10ps
module pin_sync
    import quad_dac_pkg::*;
#(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output wire logic [WIDTH-1:0] syncOut
);
    // Elaboration check: the shift below needs two stages at least
    if (WIDTH < 1 || SYNC_STAGES < 2)
    begin : gen_bad_config
        $error("pin_sync: WIDTH below 1 or fewer than two stages");
    end

    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < WIDTH; bitIdx++)
        begin : gen_bit
            logic [SYNC_STAGES-1:0] stage_r;
            // Stage 0 feeds only stage 1
            always_ff @(posedge clock)
            begin
                if (reset)
                    stage_r <= {SYNC_STAGES{RESET_VALUE[bitIdx]}};
                else
                    stage_r <= {stage_r[SYNC_STAGES-2:0], asyncIn[bitIdx]};
            end
            assign syncOut[bitIdx] = stage_r[SYNC_STAGES-1];
        end
    endgenerate
endmodule

// ---- serial_shifter.sv ----
/*
 * 16-bit input shift register with echo output launch.
 * Assumes sclk edge strobes already synchronised and one clock wide.
 */
`timescale 1ns/10ps
module serial_shifter
    import quad_dac_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    serial_frame_if.shifter  link
);
    frame_t shift_r;
    logic   spill_r;
    logic   echo_r;

    wire shiftNow   = link.selected & link.sclkRise;
    wire launchRise = shiftNow & (link.echoMode == ECHO_RISING);
    wire launchFall = link.selected & link.sclkFall & (link.echoMode == ECHO_FALLING);
    wire outgoing   = shift_r[FRAME_BITS-1];

    ////////////////////////////////////////////////////////////////////////////
    // Shift on rising edges only while selected
    always_ff @(posedge clock)
    begin
        if (reset | link.clearAll)
        begin
            shift_r <= FRAME_RESET;
            spill_r <= ECHO_BIT_RESET;
        end
        else if (shiftNow)
        begin
            shift_r <= {shift_r[FRAME_BITS-2:0], link.dinBit};
            spill_r <= outgoing;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spill bit delays the falling launch by a half period: 16.5 vs 16
    always_ff @(posedge clock)
    begin
        if (reset | link.clearAll)
            echo_r <= ECHO_BIT_RESET;
        else if (launchRise)
            echo_r <= outgoing;
        else if (launchFall)
            echo_r <= spill_r;
    end

    assign link.frame   = shift_r;
    assign link.echoBit = echo_r;
endmodule

// ---- quad_dac_serial_control.sv ----
/*
 * Digital control of a quad 12-bit converter behind a 3-wire serial port.
 * Assumes a 10 MHz system clock well faster than twice the serial clock;
 * every pin is asynchronous and passes two flops before use.
 */
`timescale 1ns/10ps
// Behaviour
// - Frame: 16 bits MSB first, sel, ctl, data
// - Ctl 01 loads one input register
// - Ctl 11 loads input, then updates all
// - Update all DACs from inputs, exit shutdown
// - Load data into everything, exit shutdown
// - Shutdown command only when lockout high
// - Misc codes drive user output low/high
// - All-zero word changes nothing
// - Echo mode select: rising or falling launch
// - Echo mode commands also update DACs
// - Echo lags input 16.5 or 16 cycles
// - Echo starts in falling-edge mode
// - Deselected: serial pins ignored
// - Selected: shift on rising serial clock
// - Command executes at select rising edge
// - Lockout falling edge wakes from shutdown
// - Echo comes from its own launch register, fed by shift register
// - Clear zeroes registers, user and echo
module quad_dac_serial_control
    import quad_dac_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 csN,
    input  wire logic                 sclk,
    input  wire logic                 din,
    input  wire logic                 clearAllN,
    input  wire logic                 shutdownLockoutN,
    output wire logic                 echoOut,
    output wire logic                 userLogicOutput,
    output wire logic                 shutdownActive,
    output wire logic                 echoRisingMode,
    output wire logic [CHANNELS-1:0][DATA_BITS-1:0] inputCode,
    output wire logic [CHANNELS-1:0][DATA_BITS-1:0] dacCode
);
    // Limitation: serial clock must stay under a quarter of clock, pins are sampled

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    localparam int PIN_COUNT = 5;
    localparam int PIN_CS    = 4;
    localparam int PIN_SCLK  = 3;
    localparam int PIN_DIN   = 2;
    localparam int PIN_CLR   = 1;
    localparam int PIN_LOCK  = 0;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h13;

    wire logic [PIN_COUNT-1:0] pinRaw;
    wire logic [PIN_COUNT-1:0] pinSync;

    assign pinRaw = {csN, sclk, din, clearAllN, shutdownLockoutN};

    pin_sync #(
        .WIDTH       (PIN_COUNT),
        .RESET_VALUE (PIN_IDLE)
    ) u_sync (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (pinRaw),
        .syncOut (pinSync)
    );

    wire csSync   = pinSync[PIN_CS];
    wire sclkSync = pinSync[PIN_SCLK];
    wire dinSync  = pinSync[PIN_DIN];
    wire clearNow = ~pinSync[PIN_CLR];
    wire lockSync = pinSync[PIN_LOCK];

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised levels
    logic csPrev_r;
    logic sclkPrev_r;
    logic lockPrev_r;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            csPrev_r   <= PIN_IDLE[PIN_CS];
            sclkPrev_r <= PIN_IDLE[PIN_SCLK];
            lockPrev_r <= PIN_IDLE[PIN_LOCK];
        end
        else
        begin
            csPrev_r   <= csSync;
            sclkPrev_r <= sclkSync;
            lockPrev_r <= lockSync;
        end
    end

    wire sclkRise = sclkSync & ~sclkPrev_r;
    wire sclkFall = ~sclkSync & sclkPrev_r;
    wire csRise   = csSync & ~csPrev_r;
    wire lockFall = ~lockSync & lockPrev_r;
    // Select must be low before and at the edge to count
    wire selected = ~csSync & ~csPrev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and echo
    serial_frame_if link ();
    echo_mode_t echoMode_r;

    assign link.sclkRise = sclkRise;
    assign link.sclkFall = sclkFall;
    assign link.selected = selected;
    assign link.dinBit   = dinSync;
    assign link.clearAll = clearNow;
    assign link.echoMode = echoMode_r;

    serial_shifter u_shifter (
        .clock (clock),
        .reset (reset),
        .link  (link)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode: only the last 16 bits shifted count
    wire logic [1:0]  selCode  = link.frame[SEL_HI_POS:SEL_LO_POS];
    wire logic [1:0]  ctlCode  = link.frame[CTL_HI_POS:CTL_LO_POS];
    wire dac_word_t   dataWord = link.frame[DATA_MSB_POS:0];

    // Nothing acts while clear is held
    wire execute = csRise & ~clearNow;

    wire isSpecial = (ctlCode == CTL_SPECIAL);
    wire isMisc    = (ctlCode == CTL_MISC);

    wire loadOne   = execute & ((ctlCode == CTL_LOAD_INPUT)
                             | (ctlCode == CTL_LOAD_UPDATE));
    wire updAfter  = execute & (ctlCode == CTL_LOAD_UPDATE);
    wire updAll    = execute & isSpecial & (selCode == SEL_UPDATE_ALL);
    wire loadAll   = execute & isSpecial & (selCode == SEL_LOAD_ALL);
    wire sdRequest = execute & isSpecial & (selCode == SEL_SHUTDOWN);
    wire sdEnter   = sdRequest & lockSync;
    wire userLow   = execute & isMisc & (selCode == SEL_USER_LOW);
    wire userHigh  = execute & isMisc & (selCode == SEL_USER_HIGH);
    wire echoFall  = execute & isMisc & (selCode == SEL_ECHO_FALL);
    wire echoRise  = execute & isMisc & (selCode == SEL_ECHO_RISE);
    wire copyAll   = updAfter | updAll | echoFall | echoRise;
    // All-zero word falls through every term above untouched
    wire anyDacUpd = copyAll | loadAll;

    ////////////////////////////////////////////////////////////////////////////
    // Input and DAC registers, one pair per channel
    dac_word_t inputReg_r [CHANNELS];
    dac_word_t dacReg_r   [CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : gen_channel
            wire logic [1:0] chCode = 2'(ch);
            wire hit = loadOne & (selCode == chCode);
            wire dac_word_t inputNxt = (loadAll | hit) ? dataWord : inputReg_r[ch];
            // Copy takes the freshly loaded word, so load then update
            wire dac_word_t dacNxt   = loadAll ? dataWord
                                     : copyAll ? inputNxt : dacReg_r[ch];

            always_ff @(posedge clock)
            begin
                if (reset | clearNow)
                begin
                    inputReg_r[ch] <= CODE_RESET;
                    dacReg_r[ch]   <= CODE_RESET;
                end
                else
                begin
                    inputReg_r[ch] <= inputNxt;
                    dacReg_r[ch]   <= dacNxt;
                end
            end

            assign inputCode[ch] = inputReg_r[ch];
            assign dacCode[ch]   = dacReg_r[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown state; registers keep contents so wake restores outputs
    logic shutdown_r;
    logic shutdown_nxt;

    always_comb
    begin
        shutdown_nxt = shutdown_r;
        if (sdEnter)
            shutdown_nxt = 1'b1;
        if (anyDacUpd | lockFall)
            shutdown_nxt = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset | clearNow)
            shutdown_r <= SHUTDOWN_RESET;
        else
            shutdown_r <= shutdown_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // User logic output
    logic userOut_r;

    always_ff @(posedge clock)
    begin
        if (reset | clearNow)
            userOut_r <= USER_OUT_RESET;
        else if (userHigh)
            userOut_r <= 1'b1;
        else if (userLow)
            userOut_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Echo launch edge; clear leaves it alone, reset or the falling echo command restores falling
    always_ff @(posedge clock)
    begin
        if (reset)
            echoMode_r <= ECHO_FALLING;
        else if (echoRise)
            echoMode_r <= ECHO_RISING;
        else if (echoFall)
            echoMode_r <= ECHO_FALLING;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign echoOut         = link.echoBit;
    assign userLogicOutput = userOut_r;
    assign shutdownActive  = shutdown_r;
    assign echoRisingMode  = (echoMode_r == ECHO_RISING);
endmodule

// ---- quad_dac_asserts.sv ----
/* Port assertions for the quad converter serial control.
   Assumes binding onto quad_dac_serial_control, one clock domain. */
`timescale 1ns/10ps
module quad_dac_asserts
    import quad_dac_pkg::*;
(
    input wire logic                                 clock,
    input wire logic                                 reset,
    input wire logic                                 csN,
    input wire logic                                 clearAllN,
    input wire logic                                 shutdownLockoutN,
    input wire logic                                 echoOut,
    input wire logic                                 userLogicOutput,
    input wire logic                                 shutdownActive,
    input wire logic                                 echoRisingMode,
    input wire logic [CHANNELS-1:0][DATA_BITS-1:0] inputCode,
    input wire logic [CHANNELS-1:0][DATA_BITS-1:0] dacCode
);
////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
////////////////////////////////////////////////////////////////////////
    reset_clears_a: assert property (disable iff (1'b0)
        reset |=> dacCode == '0 && inputCode == '0 && !echoRisingMode && !echoOut)
        else $error("reset left state behind");
    clear_zeroes_a: assert property (
        (!clearAllN)[*4] |=> dacCode == '0 && inputCode == '0 && !userLogicOutput && !echoOut)
        else $error("clear did not zero");
    // Pin sync latency is short, so six idle samples are enough
    idle_stable_a: assert property (
        (csN && clearAllN && shutdownLockoutN)[*6] |=> $stable(dacCode) && $stable(inputCode)
            && $stable(userLogicOutput) && $stable(shutdownActive) && $stable(echoOut))
        else $error("change while deselected");
    lockout_blocks_a: assert property (
        (!shutdownLockoutN)[*4] |=> !shutdownActive)
        else $error("shutdown under lockout");
    shutdown_at_cs_a: assert property (
        $rose(shutdownActive) |-> csN && $past(csN, 2) && !$past(csN, 6))
        else $error("shutdown not at select rise");
    upo_at_cs_a: assert property (
        $rose(userLogicOutput) |-> csN && $past(csN, 2) && !$past(csN, 6))
        else $error("user output not at select rise");
    dac_at_cs_a: assert property (
        clearAllN[*6] ##0 $changed(dacCode) |-> csN && $past(csN, 2) && !$past(csN, 6))
        else $error("converter code moved off command");
    mode_updates_a: assert property (
        $changed(echoRisingMode) |-> dacCode == inputCode && csN && !$past(csN, 6))
        else $error("echo mode change without update");
endmodule

bind quad_dac_serial_control quad_dac_asserts chk
(
    .clock(clock),
    .reset(reset),
    .csN(csN),
    .clearAllN(clearAllN),
    .shutdownLockoutN(shutdownLockoutN),
    .echoOut(echoOut),
    .userLogicOutput(userLogicOutput),
    .shutdownActive(shutdownActive),
    .echoRisingMode(echoRisingMode),
    .inputCode(inputCode),
    .dacCode(dacCode)
);

// ---- host_serial_model.sv ----
/* Serial host model driving select, serial clock and data.
   Assumes the bench clock; all changes land on its falling edge. */
`timescale 1ns/10ps
module host_serial_model
(
    input  wire logic clock,
    input  wire logic echoOut,
    output logic      csN,
    output logic      sclk,
    output logic      din
);
    logic [15:0] echoCap;
////////////////////////////////////////////////////////////////////////
    initial
    begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        echoCap = '0;
    end
    // Unselected data keeps moving so stale bits cannot pass
    always @(negedge clock)
        if (csN)
            din <= ~din;
////////////////////////////////////////////////////////////////////////
    task automatic startFrame;
        @(negedge clock);
        csN = 1'b0;
        @(negedge clock);
    endtask
    // Eight clocks a bit keeps the serial clock well under its limit
    task automatic shiftWord(input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
        begin
            din = w[i];
            repeat (3) @(negedge clock);
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            echoCap = {echoCap[14:0], echoOut};
            sclk = 1'b0;
            @(negedge clock);
        end
    endtask
    task automatic endFrame;
        repeat (2) @(negedge clock);
        csN = 1'b1;
        repeat (8) @(negedge clock);
    endtask
    task automatic sendWord(input logic [15:0] w);
        startFrame;
        shiftWord(w);
        endFrame;
    endtask
    task automatic idleToggle;
        repeat (6)
        begin
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            sclk = 1'b0;
            repeat (4) @(negedge clock);
        end
    endtask
endmodule

// ---- quad_dac_serial_command_control_tb.sv ----
/* Self-checking bench for the quad converter serial control.
   Assumes host_serial_model as serial master and the bound checker. */
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            errTotal++; \
            $display("ERROR %0t got %h want %h", $time, a, b); \
        end \
    end
module quad_dac_serial_command_control_tb
    import quad_dac_pkg::*;
;
    logic                              clock;
    logic                              reset;
    logic                              clearAllN;
    logic                              shutdownLockoutN;
    wire                               csN;
    wire                               sclk;
    wire                               din;
    wire                               echoOut;
    wire                               userLogicOutput;
    wire                               shutdownActive;
    wire                               echoRisingMode;
    wire [CHANNELS-1:0][DATA_BITS-1:0] inputCode;
    wire [CHANNELS-1:0][DATA_BITS-1:0] dacCode;
    logic [15:0]                       a;
    int                                inM [4];
    int                                dacM [4];
    int                                userOutM;
    int                                shutM;
    int                                modeM;
    int                                lockM;
    int                                errTotal;
    int                                comparisons;
    int                                cycles;
    int                                seed = 32'h619d;
////////////////////////////////////////////////////////////////////////
    quad_dac_serial_control DUT
    (
        .clock(clock),
        .reset(reset),
        .csN(csN),
        .sclk(sclk),
        .din(din),
        .clearAllN(clearAllN),
        .shutdownLockoutN(shutdownLockoutN),
        .echoOut(echoOut),
        .userLogicOutput(userLogicOutput),
        .shutdownActive(shutdownActive),
        .echoRisingMode(echoRisingMode),
        .inputCode(inputCode),
        .dacCode(dacCode)
    );
    host_serial_model host
    (
        .clock(clock),
        .echoOut(echoOut),
        .csN(csN),
        .sclk(sclk),
        .din(din)
    );
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
////////////////////////////////////////////////////////////////////////
    task wrapUp;
        if (errTotal == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errTotal++;
            $display("ERROR %0t timeout", $time);
            wrapUp;
        end
    end
    // Reference decode; copies use the freshly written input value
    task automatic apply(input logic [15:0] w);
        logic [1:0] s;
        logic [1:0] c;
        s = w[15:14];
        c = w[13:12];
        if (c[0])
            inM[s] = w[11:0];
        if (c == 2'h0 && s == 2'h2)
            foreach (inM[i]) inM[i] = w[11:0];
        if (c == 2'h2 && !s[1])
            userOutM = s[0];
        if (c == 2'h2 && s[1])
            modeM = s[0];
        if (c == 2'h0 && s == 2'h3 && lockM != 0)
            shutM = 1;
        if (c == 2'h3 || (c == 2'h0 && s[0] != s[1]) || (c == 2'h2 && s[1]))
        begin
            dacM = inM;
            shutM = 0;
        end
    endtask
    task automatic checkAll;
        for (int i = 0; i < 4; i++)
        begin
            `CHK(inputCode[i], inM[i][11:0])
            `CHK(dacCode[i], dacM[i][11:0])
        end
        `CHK(userLogicOutput, userOutM[0])
        `CHK(shutdownActive, shutM[0])
        `CHK(echoRisingMode, modeM[0])
    endtask
    task automatic send(input logic [15:0] w);
        host.sendWord(w);
        apply(w);
        checkAll;
    endtask
    task automatic setLock(input logic v);
        @(negedge clock);
        shutdownLockoutN = v;
        if (!v && lockM != 0)
            shutM = 0;
        lockM = v;
        repeat (6) @(negedge clock);
    endtask
////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset = 1'b1;
        clearAllN = 1'b1;
        shutdownLockoutN = 1'b1;
        lockM = 1;
        repeat (4) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        checkAll;
        for (int k = 0; k < 16; k++)
            send({k[3:0], 12'($random(seed))});
        for (int m = 0; m < 2; m++)
        begin
            send({1'b1, m[0], 2'h2, 12'h000});
            a = {2'($random(seed)), 2'h1, 12'($random(seed))};
            send(a);
            send({2'h0, 2'h1, 12'($random(seed))});
            if (m == 1)
                `CHK(host.echoCap, a)
            else
                `CHK(host.echoCap[14:0], a[15:1])
        end
        setLock(1'b0);
        send(16'hc000);
        setLock(1'b1);
        send(16'hc000);
        setLock(1'b0);
        checkAll;
        a = {2'h2, 2'h3, 12'($random(seed))};
        host.startFrame;
        host.shiftWord(16'h1fff);
        host.shiftWord(a);
        host.endFrame;
        apply(a);
        checkAll;
        host.idleToggle;
        checkAll;
        repeat (40)
        begin
            setLock(1'($random(seed)));
            send(16'($random(seed)));
        end
        @(negedge clock);
        clearAllN = 1'b0;
        repeat (6) @(negedge clock);
        `CHK(echoOut, 1'b0)
        clearAllN = 1'b1;
        foreach (inM[i]) inM[i] = 0;
        dacM = inM;
        userOutM = 0;
        shutM = 0;
        repeat (4) @(negedge clock);
        checkAll;
        wrapUp;
    end
endmodule
